/* File: verilog/dsc_defs.svh */
// field values, reset values and timing counts of the serial control block
// assumes inclusion by the design module only
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
`define DSC_CMD_BITS 4'hB
`define DSC_CMD_RST 12'h000
`define DSC_DAC_RST 10'h3FF
`define DSC_FEAT_LOAD 2'h1
`define DSC_ACT_DACWR 3'h1
`define DSC_ACT_DACRD 3'h3
`define DSC_ACT_RESET 3'h5
`define DSC_CONV_CYC 5'h10
`define DSC_NAP_CYC 5'h13
`define DSC_CHAN_LATCH 5'h2
`define DSC_FRAME_DUAL 6'h10
`define DSC_FRAME_SINGLE 6'h20
`define DSC_CH_FIRST 2'h0
`define DSC_CH_SECOND 2'h3
`define DSC_CLK_MHZ 20
`define DSC_SRST_NS 500
`define DSC_SRST_CYC ((`DSC_SRST_NS * `DSC_CLK_MHZ) / 1000)
`endif

/* File: verilog/dsc_pkg.sv */
// types shared by the serial control block and its bench
// assumes dsc_defs.svh is on the include path
package dsc_pkg;
  typedef struct packed {
    logic [1:0] chanSel;
    logic [1:0] featUpd;
    logic deepSleep;
    logic nap;
    logic autoNap;
    logic refOff;
    logic dualRead;
    logic [2:0] action;
  } dsc_cmd_t;
  typedef struct packed {
    logic convClk;
    logic readStrobe;
    logic convertStrobe;
    logic serialCommandIn;
    logic channelAutoPin;
    logic singleOutputPin;
    logic outSelN;
  } dsc_pins_t;
  typedef struct packed {
    logic serialOutA;
    logic serialOutAOeN;
    logic serialOutB;
    logic serialOutBOeN;
    logic busy;
  } dsc_sout_t;
  typedef struct packed {
    logic holdSample;
    logic [1:0] chanSel;
    logic deepSleep;
    logic nap;
    logic autoNap;
    logic refOff;
    logic [9:0] refLevel;
  } dsc_ana_t;
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_SHIFT = 3'b010,
    ACC_RST = 3'b100
  } dsc_acc_t;
  typedef enum logic [1:0] {
    CV_IDLE = 2'b01,
    CV_RUN = 2'b10
  } dsc_conv_t;
endpackage : dsc_pkg

/* File: verilog/dsc_serial_ctrl.sv */
// serial command, reference level and sample frame logic of a dual converter
// assumes host pins arrive asynchronous to clk and the conversion clock
// runs below a quarter of clk; converter results are on clk
`include "dsc_defs.svh"

module dsc_serial_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire dsc_pkg::dsc_pins_t pinsIn,
  input wire logic [11:0] adcResultA,
  input wire logic [11:0] adcResultB,
  output dsc_pkg::dsc_sout_t soutPins,
  output dsc_pkg::dsc_ana_t anaCtrl
);
  import dsc_pkg::*;

  function automatic logic featLoad(input logic [1:0] p);
    return p == `DSC_FEAT_LOAD;
  endfunction : featLoad

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  dsc_pins_t pinS1_r;
  dsc_pins_t pinS2_r;
  dsc_pins_t pinPrev_r;
  logic fallE;
  logic riseE;
  logic rdRise;
  logic cvRise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_r <= '0;
      pinS2_r <= '0;
      pinPrev_r <= '0;
    end else begin
      pinS1_r <= pinsIn;
      pinS2_r <= pinS1_r;
      pinPrev_r <= pinS2_r;
    end
  end

  assign fallE = pinPrev_r.convClk & ~pinS2_r.convClk;
  assign riseE = ~pinPrev_r.convClk & pinS2_r.convClk;
  assign rdRise = ~pinPrev_r.readStrobe & pinS2_r.readStrobe;
  assign cvRise = ~pinPrev_r.convertStrobe & pinS2_r.convertStrobe;

  //////////////////////////////////////////////////////////////////////////////
  // command access sequencer
  dsc_acc_t accState_r;
  logic [3:0] bitCnt_r;
  logic [10:0] shIn_r;
  logic [3:0] srstCnt_r;
  logic rdPend_r;
  logic accStart;
  logic wordDone;
  logic swRst;
  logic [11:0] wordIn;
  dsc_cmd_t wordCmd;
  logic dacWrArm_r;
  logic dacRdArm_r;
  logic cmdWord;

  assign accStart = (accState_r == ACC_IDLE) & fallE & rdPend_r;
  assign wordDone = (accState_r == ACC_SHIFT) & fallE & (bitCnt_r == `DSC_CMD_BITS);
  assign wordIn = {shIn_r, pinS2_r.serialCommandIn};
  assign wordCmd = dsc_cmd_t'(wordIn);
  assign swRst = accState_r == ACC_RST;
  assign cmdWord = wordDone & ~dacWrArm_r & ~dacRdArm_r;

  // a strobe seen in the same cycle as the consuming edge stays pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPend_r <= 1'b0;
    end else if (swRst) begin
      rdPend_r <= 1'b0;
    end else if (rdRise) begin
      rdPend_r <= 1'b1;
    end else if (accStart) begin
      rdPend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accState_r <= ACC_IDLE;
      bitCnt_r <= 4'h0;
      shIn_r <= '0;
      srstCnt_r <= 4'h0;
    end else begin
      unique case (accState_r)
        ACC_IDLE: begin
          if (accStart) begin
            accState_r <= ACC_SHIFT;
            bitCnt_r <= 4'h0;
          end
        end
        ACC_SHIFT: begin
          if (fallE) begin
            shIn_r <= wordIn[10:0];
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == `DSC_CMD_BITS) begin
              accState_r <= ACC_IDLE;
              if (cmdWord && wordCmd.action == `DSC_ACT_RESET) begin
                accState_r <= ACC_RST;
                srstCnt_r <= 4'(`DSC_SRST_CYC);
              end
            end
          end
        end
        ACC_RST: begin
          srstCnt_r <= srstCnt_r - 4'h1;
          if (srstCnt_r == 4'h1) begin
            accState_r <= ACC_IDLE;
            shIn_r <= '0;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command register, arms and reference level
  dsc_cmd_t cmd_r;
  logic [4:0] featEff_r;
  logic applyPend_r;
  logic [9:0] dac_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= dsc_cmd_t'(`DSC_CMD_RST);
    end else if (swRst) begin
      cmd_r <= dsc_cmd_t'(`DSC_CMD_RST);
    end else if (cmdWord) begin
      cmd_r.chanSel <= wordCmd.chanSel;
      cmd_r.featUpd <= wordCmd.featUpd;
      cmd_r.action <= wordCmd.action;
      if (featLoad(wordCmd.featUpd)) begin
        cmd_r.deepSleep <= wordCmd.deepSleep;
        cmd_r.nap <= wordCmd.nap;
        cmd_r.autoNap <= wordCmd.autoNap;
        cmd_r.refOff <= wordCmd.refOff;
        cmd_r.dualRead <= wordCmd.dualRead;
      end
    end
  end

  // stored bits reach the analog side only on the next rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      featEff_r <= 5'h00;
      applyPend_r <= 1'b0;
    end else if (swRst) begin
      featEff_r <= 5'h00;
      applyPend_r <= 1'b0;
    end else if (cmdWord) begin
      applyPend_r <= 1'b1;
    end else if (applyPend_r && riseE) begin
      featEff_r <= {cmd_r.deepSleep, cmd_r.nap, cmd_r.autoNap,
                    cmd_r.refOff, cmd_r.dualRead};
      applyPend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dacWrArm_r <= 1'b0;
      dacRdArm_r <= 1'b0;
    end else if (swRst) begin
      dacWrArm_r <= 1'b0;
      dacRdArm_r <= 1'b0;
    end else if (wordDone) begin
      dacWrArm_r <= cmdWord & (wordCmd.action == `DSC_ACT_DACWR);
      dacRdArm_r <= cmdWord & (wordCmd.action == `DSC_ACT_DACRD);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_r <= `DSC_DAC_RST;
    end else if (swRst) begin
      dac_r <= `DSC_DAC_RST;
    end else if (wordDone && dacWrArm_r) begin
      dac_r <= wordIn[9:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion timing, channel choice and results
  dsc_conv_t cvState_r;
  logic [4:0] cvCnt_r;
  logic [4:0] cvLen;
  logic [1:0] chan_r;
  logic [11:0] resA_r;
  logic [11:0] resB_r;
  logic pwrDown;
  logic cvTake;
  logic txBlock;
  logic [5:0] txCnt_r;

  assign pwrDown = featEff_r[4] | featEff_r[3];
  assign cvLen = featEff_r[2] ? `DSC_NAP_CYC : `DSC_CONV_CYC;
  assign txBlock = pinS2_r.singleOutputPin & ~featEff_r[0]
    & (txCnt_r > `DSC_FRAME_DUAL);
  assign cvTake = cvRise & (cvState_r == CV_IDLE) & ~pwrDown & ~txBlock & ~swRst;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cvState_r <= CV_IDLE;
      cvCnt_r <= 5'h00;
    end else if (swRst || pwrDown) begin
      cvState_r <= CV_IDLE;
      cvCnt_r <= 5'h00;
    end else begin
      unique case (cvState_r)
        CV_IDLE: begin
          if (cvTake) begin
            cvState_r <= CV_RUN;
            cvCnt_r <= 5'h00;
          end
        end
        CV_RUN: begin
          if (fallE) begin
            cvCnt_r <= cvCnt_r + 5'h01;
            if (cvCnt_r + 5'h01 == cvLen) begin
              cvState_r <= CV_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_r <= `DSC_CH_FIRST;
      resA_r <= 12'h000;
      resB_r <= 12'h000;
    end else if (swRst) begin
      chan_r <= `DSC_CH_FIRST;
      resA_r <= 12'h000;
      resB_r <= 12'h000;
    end else if (cvState_r == CV_RUN && fallE) begin
      if (cvCnt_r + 5'h01 == `DSC_CHAN_LATCH && !pinS2_r.channelAutoPin) begin
        chan_r <= cmd_r.chanSel;
      end
      if (cvCnt_r + 5'h01 == cvLen) begin
        resA_r <= adcResultA;
        resB_r <= adcResultB;
        if (pinS2_r.channelAutoPin) begin
          chan_r <= (chan_r == `DSC_CH_FIRST) ? `DSC_CH_SECOND : `DSC_CH_FIRST;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output frames
  logic [31:0] shA_r;
  logic [31:0] shB_r;
  logic outA_r;
  logic outB_r;
  logic [15:0] frmA;
  logic [15:0] frmB;

  assign frmA = {2'b00, resA_r, 2'b00};
  assign frmB = {2'b00, resB_r, 2'b00};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shA_r <= '0;
      shB_r <= '0;
      txCnt_r <= 6'h00;
      outA_r <= 1'b0;
      outB_r <= 1'b0;
    end else if (swRst) begin
      shA_r <= '0;
      shB_r <= '0;
      txCnt_r <= 6'h00;
      outA_r <= 1'b0;
      outB_r <= 1'b0;
    end else if (accStart) begin
      shB_r <= {frmB, 16'h0000};
      txCnt_r <= `DSC_FRAME_DUAL;
      if (dacRdArm_r) begin
        shA_r <= {4'h0, dac_r, 2'b00, 16'h0000};
      end else if (pinS2_r.singleOutputPin) begin
        shA_r <= {2'b00, resA_r, 2'b00, 2'b01, resB_r, 2'b00};
        txCnt_r <= `DSC_FRAME_SINGLE;
      end else begin
        shA_r <= {frmA, 16'h0000};
      end
    end else if (fallE) begin
      if (txCnt_r != 6'h00) begin
        outA_r <= shA_r[31];
        outB_r <= shB_r[31];
        shA_r <= {shA_r[30:0], 1'b0};
        shB_r <= {shB_r[30:0], 1'b0};
        txCnt_r <= txCnt_r - 6'h01;
      end else begin
        outA_r <= 1'b0;
        outB_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins and analog controls
  assign soutPins.serialOutA = outA_r;
  assign soutPins.serialOutAOeN = pinS2_r.outSelN;
  assign soutPins.serialOutB = outB_r;
  assign soutPins.serialOutBOeN = pinS2_r.outSelN | pinS2_r.singleOutputPin;
  assign soutPins.busy = cvState_r == CV_RUN;
  assign anaCtrl.holdSample = cvState_r == CV_RUN;
  assign anaCtrl.chanSel = chan_r;
  assign anaCtrl.deepSleep = featEff_r[4];
  assign anaCtrl.nap = featEff_r[3];
  assign anaCtrl.autoNap = featEff_r[2];
  assign anaCtrl.refOff = featEff_r[1];
  assign anaCtrl.refLevel = dac_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence sCmdWord;
    cmdWord;
  endsequence
  sequence sResetWord;
    cmdWord && wordCmd.action == `DSC_ACT_RESET;
  endsequence

  AST_CMD_CHAN: assert property (@(posedge clk) disable iff (!rst_n)
    sCmdWord |=> cmd_r.chanSel == $past(wordIn[11:10]))
    else $error("channel field not captured");

  AST_FEAT_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    sCmdWord and !featLoad(wordCmd.featUpd) |=> $stable(cmd_r[7:3]))
    else $error("feature bits changed without update code");

  AST_FEAT_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    !$stable(featEff_r) && !$past(swRst) |-> $past(riseE) && $past(applyPend_r))
    else $error("feature bits applied off a rising edge");

  AST_DAC_WR: assert property (@(posedge clk) disable iff (!rst_n)
    wordDone && dacWrArm_r |=> dac_r == $past(wordIn[9:0]) && !dacWrArm_r)
    else $error("level write not taken");

  AST_SRST: assert property (@(posedge clk) disable iff (!rst_n)
    sResetWord |=> swRst [*8] ##1 swRst [*2] ##1 !swRst ##0 cmd_r == dsc_cmd_t'(`DSC_CMD_RST))
    else $error("reset action wrong length");

  AST_BUSY_UP: assert property (@(posedge clk) disable iff (!rst_n)
    cvTake |=> soutPins.busy && anaCtrl.holdSample)
    else $error("busy not raised on strobe");

  AST_CONV_END: assert property (@(posedge clk) disable iff (!rst_n)
    cvState_r == CV_RUN && fallE && cvCnt_r == cvLen - 5'h01 && !pwrDown && !swRst
    |=> !soutPins.busy && resA_r == $past(adcResultA))
    else $error("conversion did not end on its last edge");

  AST_CHAN_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    cvState_r == CV_RUN && fallE && cvCnt_r == 5'h01 && !pinS2_r.channelAutoPin
    && !pwrDown && !swRst |=> chan_r == $past(cmd_r.chanSel))
    else $error("channel not latched on second edge");

  AST_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    cvRise && txBlock && cvState_r == CV_IDLE |=> !soutPins.busy)
    else $error("strobe during long frame not dropped");

  AST_B_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
    pinS2_r.singleOutputPin |-> soutPins.serialOutBOeN)
    else $error("output B driven in single output mode");

  AST_FRAME_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    accStart && !pinS2_r.singleOutputPin |=> txCnt_r == `DSC_FRAME_DUAL && !shA_r[31])
    else $error("dual frame not loaded");

endmodule : dsc_serial_ctrl

/* File: bench/dsc_host_model.sv */
// host side of the serial control block: strobes, conversion clock, command line
// assumes the bench clock clk; conversion clock runs at one eighth of clk
module dsc_host_model (
  input wire logic clk,
  input wire logic autoPin,
  input wire logic singlePin,
  input wire dsc_pkg::dsc_sout_t sout,
  output dsc_pkg::dsc_pins_t pins,
  output logic [31:0] capA,
  output logic [31:0] capB,
  output logic busyAtStart
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsc_pkg::*;

  logic cclk;
  logic rdS;
  logic cvS;
  logic serial_command_in;

  // output select held low so output A is enabled, and output B unless the single output pin is high
  assign pins = {cclk, rdS, cvS, serial_command_in, autoPin, singlePin, 1'b0};

  initial begin
    cclk = 1'b0;
    rdS = 1'b0;
    cvS = 1'b0;
    serial_command_in = 1'b0;
    capA = '0;
    capB = '0;
    busyAtStart = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one access: strobe, then nEdges falling edges; clock stands low between accesses
  task automatic access(input logic [11:0] word, input int nEdges, input logic conv);
    logic [11:0] sh;
    sh = word;
    capA = '0;
    capB = '0;
    @(negedge clk);
    rdS <= 1'b1;
    cvS <= conv;
    repeat (4) @(negedge clk);
    rdS <= 1'b0;
    cvS <= 1'b0;
    for (int e = 0; e < nEdges; e++) begin
      cclk <= 1'b1;
      // word shifted most significant bit first on edges 1 to 12
      if (e >= 1 && e <= 12) begin
        serial_command_in <= sh[11];
        sh = {sh[10:0], 1'b0};
      end
      repeat (4) @(negedge clk);
      if (e == 0) begin
        busyAtStart = sout.busy;
      end
      cclk <= 1'b0;
      repeat (4) @(negedge clk);
      // the bit launched by this falling edge has passed the synchronisers by now
      if (e >= 1) begin
        capA = {capA[30:0], sout.serialOutA};
        capB = {capB[30:0], sout.serialOutB};
      end
    end
    // a released command line is left at the inverse of its last bit
    serial_command_in <= ~serial_command_in;
  endtask : access

  // a lone convert strobe, raised waitClk cycles into a running access
  task automatic mid_strobe(input int waitClk);
    repeat (waitClk) @(negedge clk);
    cvS <= 1'b1;
    repeat (4) @(negedge clk);
    cvS <= 1'b0;
    repeat (4) @(negedge clk);
  endtask : mid_strobe
endmodule : dsc_host_model

/* File: bench/testbench.sv */
// self-checking bench of the serial control block
// assumes dsc_pkg and the host model are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dsc_pkg::*;

  logic clk;
  logic rst_n;
  logic [11:0] resA;
  logic [11:0] resB;
  logic autoPin;
  logic singlePin;
  dsc_pins_t pins;
  dsc_sout_t sout;
  dsc_ana_t ana;
  logic [31:0] capA;
  logic [31:0] capB;
  logic busyAtStart;
  int num_errors;
  int checked;

  always #25 clk = ~clk;

  dsc_serial_ctrl dsc_serial_ctrl_i (.clk(clk), .rst_n(rst_n), .pinsIn(pins),
    .adcResultA(resA), .adcResultB(resB), .soutPins(sout), .anaCtrl(ana));
  dsc_host_model dsc_host_model_i (.clk(clk), .autoPin(autoPin), .singlePin(singlePin),
    .sout(sout), .pins(pins), .capA(capA), .capB(capB), .busyAtStart(busyAtStart));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic acc(input logic [11:0] w, input int n, input logic cv);
    dsc_host_model_i.access(w, n, cv);
  endtask : acc

  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check(32'(ana.refLevel), 32'h3FF);
    check(32'(ana.chanSel), 32'h0);
    check(32'({ana.deepSleep, ana.nap, ana.autoNap, ana.refOff}), 32'h0);
    check(32'(sout.busy), 32'h0);
    check(32'(sout.serialOutAOeN), 32'h0);
  endtask : test_reset

  task automatic test_dual_frame();
    logic [11:0] va [2];
    logic [11:0] vb [2];
    va = '{12'h7FF, 12'hFFF};
    vb = '{12'h800, 12'h000};
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      resA = va[i];
      resB = vb[i];
      acc(12'h000, 17, 1'b1);
      check(32'(busyAtStart), 32'h1);
      check(32'(sout.busy), 32'h0);
      acc(12'h000, 17, 1'b0);
      check(capA, 32'({2'b00, va[i], 2'b00}));
      check(capB, 32'({2'b00, vb[i], 2'b00}));
    end
  endtask : test_dual_frame

  task automatic test_features();
    acc(12'h010, 17, 1'b0);
    check(32'(ana.refOff), 32'h0);
    acc(12'h118, 17, 1'b0);
    check(32'(ana.refOff), 32'h1);
    acc(12'h300, 17, 1'b0);
    check(32'(ana.refOff), 32'h1);
    acc(12'h140, 17, 1'b0);
    check(32'({ana.nap, ana.refOff}), 32'h2);
    acc(12'h000, 17, 1'b1);
    check(32'(busyAtStart), 32'h0);
    acc(12'h180, 17, 1'b0);
    check(32'({ana.deepSleep, ana.nap}), 32'h2);
    acc(12'h120, 17, 1'b0);
    check(32'({ana.deepSleep, ana.autoNap}), 32'h1);
    acc(12'h100, 17, 1'b0);
    check(32'({ana.deepSleep, ana.nap, ana.autoNap, ana.refOff}), 32'h0);
  endtask : test_features

  task automatic test_channel();
    for (int c = 0; c < 4; c++) begin
      acc({2'(c), 10'h000}, 17, 1'b0);
      acc({2'(c), 10'h000}, 17, 1'b1);
      check(32'(ana.chanSel), 32'(c));
    end
  endtask : test_channel

  task automatic test_level();
    acc(12'h101, 17, 1'b0);
    acc(12'hEA5, 17, 1'b0);
    check(32'(ana.refLevel), 32'h2A5);
    acc(12'h103, 17, 1'b0);
    acc(12'h000, 17, 1'b0);
    check(capA, 32'({4'h0, 10'h2A5, 2'b00}));
  endtask : test_level

  task automatic test_single();
    @(negedge clk);
    singlePin = 1'b1;
    resA = 12'h123;
    resB = 12'hABC;
    repeat (6) @(negedge clk);
    check(32'(sout.serialOutBOeN), 32'h1);
    acc(12'h000, 33, 1'b1);
    fork
      acc(12'h000, 33, 1'b0);
      begin
        dsc_host_model_i.mid_strobe(40);
        check(32'(sout.busy), 32'h0);
      end
    join
    check(capA, {2'b00, 12'h123, 2'b00, 2'b01, 12'hABC, 2'b00});
    acc(12'h108, 33, 1'b0);
    fork
      acc(12'h000, 33, 1'b0);
      begin
        dsc_host_model_i.mid_strobe(40);
        check(32'(sout.busy), 32'h1);
      end
    join
    acc(12'h100, 33, 1'b0);
    singlePin = 1'b0;
  endtask : test_single

  task automatic test_auto();
    acc(12'h000, 17, 1'b0);
    acc(12'h000, 17, 1'b1);
    @(negedge clk);
    autoPin = 1'b1;
    acc(12'h000, 17, 1'b1);
    check(32'(ana.chanSel), 32'h3);
    acc(12'h000, 17, 1'b1);
    check(32'(ana.chanSel), 32'h0);
    autoPin = 1'b0;
  endtask : test_auto

  task automatic test_soft_reset();
    acc(12'h101, 17, 1'b0);
    acc(12'h055, 17, 1'b0);
    check(32'(ana.refLevel), 32'h055);
    acc(12'h110, 17, 1'b0);
    check(32'(ana.refOff), 32'h1);
    acc(12'h005, 17, 1'b0);
    repeat (20) @(negedge clk);
    check(32'(ana.refLevel), 32'h3FF);
    check(32'(ana.refOff), 32'h0);
    acc(12'h118, 17, 1'b0);
    check(32'(ana.refOff), 32'h1);
  endtask : test_soft_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    resA = '0;
    resB = '0;
    autoPin = 1'b0;
    singlePin = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    test_reset();
    test_dual_frame();
    test_features();
    test_channel();
    test_level();
    test_single();
    test_auto();
    test_soft_reset();
    finish_test();
  end
endmodule : testbench
